//--- shared/fwg_pkg.sv
// Behaviour
// - Page programs alone, only clearing bits
// - Erase by subsector, sector or array; sets bits
// - Array 2 MiB: 32 sectors, 512 subsectors
// - Separate 64-byte one-time area outside array
// - Sector n spans n*10000h up to +FFFFh
// - Refuse modifying frames with partial last byte
// - Modifying commands need write-enable latch set
// - Sector write-lock bit blocks program and erase
// - Lock-down freezes sector protection until reset
// - Lock bits change only by lock write
// - Range bits guard top sectors, bottom flag clear
// - Range bits guard bottom sectors, flag set
// - Write-protect pin low freezes range bits, except in quad mode
package fwg_pkg;
  // Array geometry
  localparam int unsigned ARRAY_BYTES = 2097152;
  localparam int unsigned SECTOR_COUNT = 32;
  localparam int unsigned SUB4_COUNT = 512;
  localparam int unsigned PAGE_COUNT = 8192;
  localparam int unsigned PAGE_BYTES = 256;
  localparam int unsigned OTP_BYTES = 64;
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned SECTOR_LSB = 16;
  localparam int unsigned SUB32_LSB = 15;
  localparam int unsigned SUB4_LSB = 12;
  localparam logic [20:0] ADDR_LAST = 21'h1fffff;
  localparam logic [20:0] MASK_SUB4 = 21'h1ff000;
  localparam logic [20:0] MASK_SUB32 = 21'h1f8000;
  localparam logic [20:0] MASK_SECTOR = 21'h1f0000;
  localparam logic [20:0] MASK_OTP = 21'h00003f;
  // Frame layout: opcode then three address bytes
  localparam logic [9:0] HDR_BYTES = 10'h004;
  localparam logic [9:0] LEN_STATUS = 10'h002;
  localparam logic [9:0] LEN_LOCK = 10'h005;
  localparam logic [9:0] LEN_PROG = 10'h005;
  localparam logic [9:0] RX_CNT_MAX = 10'h3ff;
  localparam logic [8:0] PAGE_CNT_FULL = 9'h100;
  localparam logic [8:0] OTP_CNT_FULL = 9'h040;
  // Command codes
  localparam logic [7:0] OPC_WR_EN = 8'h06;
  localparam logic [7:0] OPC_WR_DIS = 8'h04;
  localparam logic [7:0] OPC_PROG = 8'h02;
  localparam logic [7:0] OPC_OTP_PROG = 8'h42;
  localparam logic [7:0] OPC_ERASE_4K = 8'h20;
  localparam logic [7:0] OPC_ERASE_32K = 8'h52;
  localparam logic [7:0] OPC_ERASE_64K = 8'hd8;
  localparam logic [7:0] OPC_ERASE_ALL = 8'hc7;
  localparam logic [7:0] OPC_STATUS_WR = 8'h01;
  localparam logic [7:0] OPC_LOCK_WR = 8'he5;
  // Field positions in status and lock data bytes
  localparam int unsigned STAT_BP_LSB = 2;
  localparam int unsigned STAT_TB_POS = 5;
  localparam int unsigned LOCK_WR_POS = 0;
  localparam int unsigned LOCK_DN_POS = 1;
  // Reset values and synchronizer depth
  localparam logic [2:0] BP_RESET = 3'h0;
  localparam logic TB_RESET = 1'b0;
  localparam logic [31:0] LOCK_RESET = 32'h0000_0000;
  localparam int unsigned SYNC_STAGES = 3;
  // Array operation handed to the cell array
  typedef enum logic [2:0] {
    ARR_PROG = 3'h0,
    ARR_OTP_PROG = 3'h1,
    ARR_ERASE_4K = 3'h2,
    ARR_ERASE_32K = 3'h3,
    ARR_ERASE_64K = 3'h4,
    ARR_ERASE_ALL = 3'h5
  } fwg_arr_op_e;
  typedef struct packed {
    fwg_arr_op_e op;
    logic [20:0] addr;
    logic [7:0] data;
  } fwg_arr_req_s;
  typedef struct packed {
    logic busy;
    logic wel;
    logic tb;
    logic [2:0] bp;
  } fwg_status_s;
  // Range-guard decode of one sector
  function automatic logic fwg_range_hit(input logic [2:0] bp, input logic tb, input logic [4:0] sec);
    logic [5:0] span;
    span = 6'h00;
    unique case (bp)
      3'h0: span = 6'h00;
      3'h1: span = 6'h01;
      3'h2: span = 6'h02;
      3'h3: span = 6'h04;
      3'h4: span = 6'h08;
      3'h5: span = 6'h10;
      default: span = 6'h20;
    endcase
    if (tb)
    begin
      return {1'b0, sec} < span;
    end
    return {1'b0, sec} >= (6'h20 - span);
  endfunction
endpackage

//--- logic/fwg_sync.sv
`timescale 1ns/100ps
module fwg_sync
  import fwg_pkg::*;
#(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned STAGES = SYNC_STAGES
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q,
  output logic [WIDTH-1:0] q_prev
);
  // Chain of samples, index 0 is the first flop
  logic [WIDTH-1:0] chain_reg [STAGES];
  logic [WIDTH-1:0] chain_next [STAGES];

  // Shift every stage one step
  always_comb
  begin
    chain_next[0] = d;
    for (int i = 1; i < STAGES; i++)
    begin
      chain_next[i] = chain_reg[i-1];
    end
  end

  // Register the chain
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < STAGES; i++)
      begin
        chain_reg[i] <= '0;
      end
    end
    else
    begin
      chain_reg <= chain_next;
    end
  end

  // Only the last two stages leave; the first is never looked at
  assign q = chain_reg[STAGES-1];
  assign q_prev = chain_reg[STAGES-2];
endmodule

//--- logic/fwg_page_buf.sv
`timescale 1ns/100ps
module fwg_page_buf
  import fwg_pkg::*;
#(
  parameter int unsigned DW = 8,
  parameter int unsigned DEPTH = PAGE_BYTES
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  // Storage needs no reset; contents are always written before use
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rd_data_reg;
  logic [DW-1:0] rd_data_next;

  // Write port
  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read every cycle from the presented address
  always_comb
  begin
    rd_data_next = mem[rd_addr];
  end

  // Registered read data
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_reg <= '0;
    end
    else
    begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;
endmodule

//--- logic/fwg_guard.sv
`timescale 1ns/100ps
module fwg_guard
  import fwg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic sdi,
  input wire logic wp_n,
  input wire logic quad_mode,
  output fwg_arr_req_s arr_req,
  output logic arr_valid,
  input wire logic arr_ready,
  output fwg_status_s status,
  output logic [31:0] lock_write,
  output logic [31:0] lock_down,
  output logic cmd_done,
  output logic cmd_refused
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_FRAME = 6'b000010,
    ST_CHECK = 6'b000100,
    ST_READ = 6'b001000,
    ST_ISSUE = 6'b010000,
    ST_DONE = 6'b100000
  } fwg_state_e;

  // ---- Link domain, clocked by the serial clock ----
  logic lk_clr_n; // Held in clear while deselected
  logic [2:0] lk_cnt_reg, lk_cnt_next;
  logic [6:0] lk_shift_reg, lk_shift_next;
  logic [7:0] lk_byte_reg, lk_byte_next;
  logic lk_tog_reg, lk_tog_next;
  logic lk_part_reg, lk_part_next;

  assign lk_clr_n = rst_n & ~sel_n;

  // Bit gathering, MSB first; partial flag outlives the frame
  always_comb
  begin
    lk_cnt_next = lk_cnt_reg + 3'h1;
    lk_shift_next = {lk_shift_reg[5:0], sdi};
    lk_byte_next = lk_byte_reg;
    lk_tog_next = lk_tog_reg;
    if (lk_cnt_reg == 3'h7)
    begin
      lk_byte_next = {lk_shift_reg, sdi};
      lk_tog_next = ~lk_tog_reg;
    end
    lk_part_next = (lk_cnt_next != 3'h0);
  end

  // Counter restarts with every frame
  always_ff @(posedge sclk or negedge lk_clr_n)
  begin
    if (!lk_clr_n)
    begin
      lk_cnt_reg <= 3'h0;
      lk_shift_reg <= 7'h00;
    end
    else
    begin
      lk_cnt_reg <= lk_cnt_next;
      lk_shift_reg <= lk_shift_next;
    end
  end

  // Byte, toggle and partial flag hold across frame gaps
  always_ff @(posedge sclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lk_byte_reg <= 8'h00;
      lk_tog_reg <= 1'b0;
      lk_part_reg <= 1'b0;
    end
    else
    begin
      lk_byte_reg <= lk_byte_next;
      lk_tog_reg <= lk_tog_next;
      lk_part_reg <= lk_part_next;
    end
  end

  // ---- Crossings into the core domain ----
  logic [1:0] pin_q, pin_qp; // {wp_n, sel_n}
  logic [1:0] lk_q, lk_qp; // {partial, toggle}

  fwg_sync #(.WIDTH(2), .STAGES(SYNC_STAGES)) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({wp_n, sel_n}),
    .q(pin_q),
    .q_prev(pin_qp)
  );

  fwg_sync #(.WIDTH(2), .STAGES(SYNC_STAGES)) u_link_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({lk_part_reg, lk_tog_reg}),
    .q(lk_q),
    .q_prev(lk_qp)
  );

  // ---- Core state ----
  fwg_state_e state_reg, state_next;
  logic sel_lvl_reg, sel_lvl_next; // Filtered select level
  logic sel_prev_reg, sel_prev_next;
  logic wp_lvl_reg, wp_lvl_next; // Filtered write-protect level
  logic [7:0] opcode_reg, opcode_next;
  logic [20:0] addr_reg, addr_next;
  logic [7:0] aux_reg, aux_next; // Status or lock data byte
  logic [9:0] rx_cnt_reg, rx_cnt_next;
  logic [8:0] idx_reg, idx_next;
  logic [20:0] cur_addr_reg, cur_addr_next;
  fwg_arr_op_e op_reg, op_next;
  logic wel_reg, wel_next;
  logic [2:0] bp_reg, bp_next;
  logic tb_reg, tb_next;
  logic [31:0] lock_wr_reg, lock_wr_next;
  logic [31:0] lock_dn_reg, lock_dn_next;
  logic done_reg, done_next;
  logic refused_reg, refused_next;

  // Decoded helpers
  logic byte_evt, sel_fall, sel_rise, whole, is_modify, sec_prot, any_prot, frozen;
  logic [4:0] sector;
  logic [8:0] data_cnt;
  logic buf_we;
  logic [7:0] buf_rdata;

  assign byte_evt = lk_q[0] ^ lk_qp[0];
  assign sel_fall = sel_prev_reg & ~sel_lvl_reg;
  assign sel_rise = ~sel_prev_reg & sel_lvl_reg;
  assign whole = ~lk_q[1];
  assign sector = addr_reg[20:16];
  assign frozen = ~wp_lvl_reg & ~quad_mode; // W# is data in quad mode
  assign buf_we = (state_reg == ST_FRAME) & byte_evt & (rx_cnt_reg >= HDR_BYTES)
    & ((opcode_reg == OPC_PROG) | (opcode_reg == OPC_OTP_PROG));

  // Page data staged until the frame proves whole
  fwg_page_buf #(.DW(8), .DEPTH(PAGE_BYTES)) u_page_buf (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(buf_we),
    .wr_addr(8'(rx_cnt_reg - HDR_BYTES)),
    .wr_data(lk_byte_reg),
    .rd_addr(idx_reg[7:0]),
    .rd_data(buf_rdata)
  );

  // Protection decode and frame classification
  always_comb
  begin
    is_modify = (opcode_reg == OPC_PROG) || (opcode_reg == OPC_OTP_PROG)
      || (opcode_reg == OPC_ERASE_4K) || (opcode_reg == OPC_ERASE_32K)
      || (opcode_reg == OPC_ERASE_64K) || (opcode_reg == OPC_ERASE_ALL)
      || (opcode_reg == OPC_STATUS_WR) || (opcode_reg == OPC_LOCK_WR);
    sec_prot = fwg_range_hit(bp_reg, tb_reg, sector) | lock_wr_reg[sector];
    any_prot = 1'b0;
    for (int i = 0; i < SECTOR_COUNT; i++)
    begin
      any_prot = any_prot | fwg_range_hit(bp_reg, tb_reg, 5'(i)) | lock_wr_reg[i];
    end
    // Extra bytes beyond a page wrap and overwrite the oldest
    if (opcode_reg == OPC_OTP_PROG)
    begin
      data_cnt = (rx_cnt_reg >= HDR_BYTES + 10'(OTP_CNT_FULL)) ? OTP_CNT_FULL : 9'(rx_cnt_reg - HDR_BYTES);
    end
    else
    begin
      data_cnt = (rx_cnt_reg >= HDR_BYTES + 10'(PAGE_CNT_FULL)) ? PAGE_CNT_FULL : 9'(rx_cnt_reg - HDR_BYTES);
    end
  end

  // Next-state logic for the whole core
  always_comb
  begin
    state_next = state_reg;
    sel_lvl_next = (pin_q[0] == pin_qp[0]) ? pin_q[0] : sel_lvl_reg;
    wp_lvl_next = (pin_q[1] == pin_qp[1]) ? pin_q[1] : wp_lvl_reg;
    sel_prev_next = sel_lvl_reg;
    opcode_next = opcode_reg;
    addr_next = addr_reg;
    aux_next = aux_reg;
    rx_cnt_next = rx_cnt_reg;
    idx_next = idx_reg;
    cur_addr_next = cur_addr_reg;
    op_next = op_reg;
    wel_next = wel_reg;
    bp_next = bp_reg;
    tb_next = tb_reg;
    lock_wr_next = lock_wr_reg;
    lock_dn_next = lock_dn_reg;
    done_next = 1'b0;
    refused_next = 1'b0;
    unique case (state_reg)
      ST_IDLE:
      begin
        // Frames starting while busy are dropped entirely
        if (sel_fall)
        begin
          rx_cnt_next = 10'h000;
          opcode_next = 8'h00;
          state_next = ST_FRAME;
        end
      end
      ST_FRAME:
      begin
        if (byte_evt)
        begin
          rx_cnt_next = (rx_cnt_reg == RX_CNT_MAX) ? rx_cnt_reg : rx_cnt_reg + 10'h001;
          if (rx_cnt_reg == 10'h000)
          begin
            opcode_next = lk_byte_reg;
          end
          else if (rx_cnt_reg < HDR_BYTES)
          begin
            addr_next = {addr_reg[12:0], lk_byte_reg};
          end
          if ((rx_cnt_reg == 10'h001) || (rx_cnt_reg == HDR_BYTES))
          begin
            aux_next = lk_byte_reg;
          end
        end
        else if (sel_rise)
        begin
          state_next = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        state_next = ST_IDLE;
        if (!whole)
        begin
          // Partial byte: nothing executes
          refused_next = is_modify;
        end
        else if (opcode_reg == OPC_WR_EN)
        begin
          wel_next = 1'b1;
          done_next = 1'b1;
        end
        else if (opcode_reg == OPC_WR_DIS)
        begin
          wel_next = 1'b0;
          done_next = 1'b1;
        end
        else if (is_modify && !wel_reg)
        begin
          refused_next = 1'b1;
        end
        else
        begin
          unique case (opcode_reg)
            OPC_STATUS_WR:
            begin
              if (frozen || (rx_cnt_reg < LEN_STATUS))
              begin
                refused_next = 1'b1;
              end
              else
              begin
                bp_next = aux_reg[STAT_BP_LSB +: 3];
                tb_next = aux_reg[STAT_TB_POS];
                state_next = ST_DONE;
              end
            end
            OPC_LOCK_WR:
            begin
              if (lock_dn_reg[sector] || (rx_cnt_reg < LEN_LOCK))
              begin
                refused_next = 1'b1;
              end
              else
              begin
                lock_wr_next[sector] = aux_reg[LOCK_WR_POS];
                lock_dn_next[sector] = aux_reg[LOCK_DN_POS];
                state_next = ST_DONE;
              end
            end
            OPC_PROG, OPC_OTP_PROG:
            begin
              // One-time area bypasses sector guards; it is not in the array
              if ((rx_cnt_reg < LEN_PROG) || ((opcode_reg == OPC_PROG) && sec_prot))
              begin
                refused_next = 1'b1;
              end
              else
              begin
                op_next = (opcode_reg == OPC_PROG) ? ARR_PROG : ARR_OTP_PROG;
                cur_addr_next = (opcode_reg == OPC_PROG) ? addr_reg : (addr_reg & MASK_OTP);
                idx_next = 9'h000;
                state_next = ST_READ;
              end
            end
            OPC_ERASE_4K, OPC_ERASE_32K, OPC_ERASE_64K:
            begin
              if ((rx_cnt_reg < HDR_BYTES) || sec_prot)
              begin
                refused_next = 1'b1;
              end
              else
              begin
                // Base is aligned to the erased unit
                if (opcode_reg == OPC_ERASE_4K)
                begin
                  op_next = ARR_ERASE_4K;
                  cur_addr_next = addr_reg & MASK_SUB4;
                end
                else if (opcode_reg == OPC_ERASE_32K)
                begin
                  op_next = ARR_ERASE_32K;
                  cur_addr_next = addr_reg & MASK_SUB32;
                end
                else
                begin
                  op_next = ARR_ERASE_64K;
                  cur_addr_next = addr_reg & MASK_SECTOR;
                end
                state_next = ST_ISSUE;
              end
            end
            OPC_ERASE_ALL:
            begin
              if (any_prot)
              begin
                refused_next = 1'b1;
              end
              else
              begin
                op_next = ARR_ERASE_ALL;
                cur_addr_next = 21'h000000;
                state_next = ST_ISSUE;
              end
            end
            default:
            begin
              state_next = ST_IDLE; // Unknown opcodes are ignored quietly
            end
          endcase
        end
      end
      ST_READ:
      begin
        state_next = ST_ISSUE; // Buffer data lands next cycle
      end
      ST_ISSUE:
      begin
        if (arr_ready)
        begin
          if ((op_reg == ARR_PROG) || (op_reg == ARR_OTP_PROG))
          begin
            // Address wraps inside the page or one-time area
            if (op_reg == ARR_PROG)
            begin
              cur_addr_next = {cur_addr_reg[20:8], cur_addr_reg[7:0] + 8'h01};
            end
            else
            begin
              cur_addr_next = {cur_addr_reg[20:6], cur_addr_reg[5:0] + 6'h01};
            end
            idx_next = idx_reg + 9'h001;
            state_next = (idx_reg + 9'h001 == data_cnt) ? ST_DONE : ST_READ;
          end
          else
          begin
            state_next = ST_DONE;
          end
        end
      end
      ST_DONE:
      begin
        wel_next = 1'b0;
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
  end

  // Core registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      sel_lvl_reg <= 1'b1;
      sel_prev_reg <= 1'b1;
      wp_lvl_reg <= 1'b1;
      opcode_reg <= 8'h00;
      addr_reg <= 21'h000000;
      aux_reg <= 8'h00;
      rx_cnt_reg <= 10'h000;
      idx_reg <= 9'h000;
      cur_addr_reg <= 21'h000000;
      op_reg <= ARR_PROG;
      wel_reg <= 1'b0;
      bp_reg <= BP_RESET;
      tb_reg <= TB_RESET;
      lock_wr_reg <= LOCK_RESET;
      lock_dn_reg <= LOCK_RESET;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      sel_lvl_reg <= sel_lvl_next;
      sel_prev_reg <= sel_prev_next;
      wp_lvl_reg <= wp_lvl_next;
      opcode_reg <= opcode_next;
      addr_reg <= addr_next;
      aux_reg <= aux_next;
      rx_cnt_reg <= rx_cnt_next;
      idx_reg <= idx_next;
      cur_addr_reg <= cur_addr_next;
      op_reg <= op_next;
      wel_reg <= wel_next;
      bp_reg <= bp_next;
      tb_reg <= tb_next;
      lock_wr_reg <= lock_wr_next;
      lock_dn_reg <= lock_dn_next;
      done_reg <= done_next;
      refused_reg <= refused_next;
    end
  end

  // Outputs
  assign arr_valid = (state_reg == ST_ISSUE);
  assign arr_req = '{op: op_reg, addr: cur_addr_reg, data: buf_rdata};
  assign status = '{busy: (state_reg != ST_IDLE) && (state_reg != ST_FRAME), wel: wel_reg, tb: tb_reg, bp: bp_reg};
  assign lock_write = lock_wr_reg;
  assign lock_down = lock_dn_reg;
  assign cmd_done = done_reg;
  assign cmd_refused = refused_reg;

  // ---- Assertions ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_page_bound: assert property (arr_valid && (arr_req.op == ARR_PROG) |-> arr_req.addr[20:8] == addr_reg[20:8])
    else $error("program left its page");
  a_erase_aligned: assert property (arr_valid && (arr_req.op == ARR_ERASE_4K) |-> arr_req.addr[11:0] == 12'h000)
    else $error("subsector erase not aligned");
  a_sector_base: assert property (arr_valid && (arr_req.op == ARR_ERASE_64K) |-> arr_req.addr[15:0] == 16'h0000)
    else $error("sector erase not aligned");
  a_otp_apart: assert property (arr_valid && (arr_req.op == ARR_OTP_PROG) |-> arr_req.addr[20:6] == 15'h0000)
    else $error("one-time address outside area");
  a_partial_refused: assert property ((state_reg == ST_CHECK) && !whole |=> (state_reg == ST_IDLE) && !cmd_done)
    else $error("partial frame executed");
  a_wel_needed: assert property ((state_reg == ST_CHECK) && is_modify && !wel_reg |=> cmd_refused || !whole)
    else $error("modify without write enable");
  a_lock_blocks: assert property (arr_valid && (arr_req.op == ARR_PROG) |-> !lock_wr_reg[arr_req.addr[20:16]])
    else $error("program into locked sector");
  a_range_guard: assert property (arr_valid && (arr_req.op != ARR_OTP_PROG) && (arr_req.op != ARR_ERASE_ALL)
    |-> !fwg_range_hit(bp_reg, tb_reg, arr_req.addr[20:16]))
    else $error("write into guarded range");
  a_lockdown_frozen: assert property (##1 (($past(lock_dn_reg) & (lock_wr_reg ^ $past(lock_wr_reg))) == 32'h0))
    else $error("locked-down sector changed");
  a_lock_cmd_only: assert property ((lock_wr_reg != $past(lock_wr_reg)) |-> $past(opcode_reg) == OPC_LOCK_WR)
    else $error("lock bits changed by other command");
  a_wp_freeze: assert property ((state_reg == ST_CHECK) && frozen |=> $stable(bp_reg) && $stable(tb_reg))
    else $error("range bits changed while pin low");
  a_reset_clear: assert property (@(posedge clock) disable iff (1'b0)
    $rose(rst_n) |-> (lock_wr_reg == 32'h0) && (lock_dn_reg == 32'h0))
    else $error("lock bits not clear after reset");
  a_link_byte: assert property (@(posedge sclk) disable iff (!lk_clr_n)
    (lk_cnt_reg == 3'h7) |=> (lk_tog_reg != $past(lk_tog_reg)) && !lk_part_reg)
    else $error("byte toggle missing");

  c_prog_issued: cover property (arr_valid && arr_ready && (arr_req.op == ARR_PROG));
  c_erase_issued: cover property (arr_valid && arr_ready && (arr_req.op == ARR_ERASE_64K));
  c_refused: cover property (cmd_refused);
  c_lock_down: cover property ($rose(|lock_dn_reg));
endmodule

//--- tb/fwg_host_model.sv
`timescale 1ns/100ps
module fwg_host_model
(
  output logic sclk,
  output logic sel_n,
  output logic sdi
);
  // Idle: deselected, link clock parked low
  initial
  begin
    sclk = 1'b0;
    sel_n = 1'b1;
    sdi = 1'b0;
  end
  // One frame, MSB first; clock runs only inside the frame
  task automatic send(input logic [63:0] bits, input int nbits);
    #2.3 sel_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      sdi = bits[i];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    // Released data line must not look like a held bit
    sdi = ~sdi;
    // Returns at once so the caller can catch the outcome pulse
    #20 sel_n = 1'b1;
  endtask
endmodule

//--- tb/test_fwg_guard.sv
`timescale 1ns/100ps
module test_fwg_guard
  import fwg_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n, wp_n, quad_mode, arr_ready, arr_valid, cmd_done, cmd_refused, sclk, sel_n, sdi;
  fwg_arr_req_s arr_req, last;
  fwg_status_s status;
  logic [31:0] lock_write, lock_down;
  int num_errors = 0, n_checks = 0, n_arr = 0, cycles = 0;
  fwg_guard dut (.clock(clock), .rst_n(rst_n), .sclk(sclk), .sel_n(sel_n), .sdi(sdi), .wp_n(wp_n),
    .quad_mode(quad_mode), .arr_req(arr_req), .arr_valid(arr_valid), .arr_ready(arr_ready), .status(status),
    .lock_write(lock_write), .lock_down(lock_down), .cmd_done(cmd_done), .cmd_refused(cmd_refused));
  fwg_host_model host (.sclk(sclk), .sel_n(sel_n), .sdi(sdi));
  // Core clock, 5 ns
  always #2.5 clock = ~clock;
  // Array side accepts one cycle late, and records each handshake
  always @(posedge clock)
  begin
    arr_ready <= arr_valid & ~arr_ready;
    if (arr_valid === 1'b1 && arr_ready === 1'b1)
    begin
      last <= arr_req;
      n_arr <= n_arr + 1;
    end
    cycles <= cycles + 1;
    // Hang guard: whole run is far below this
    if (cycles == 40000)
    begin
      num_errors++;
      $display("BAD %0t run timed out", $time);
      give_verdict();
    end
  end
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // Send a frame, wait bounded for the pulse; refusal must touch no cell
  task automatic run(input logic [63:0] b, input int n, input logic ok);
    logic d, r;
    int a;
    d = 1'b0;
    r = 1'b0;
    a = n_arr;
    host.send(b, n);
    for (int i = 0; i < 300 && !(d | r); i++)
    begin
      @(negedge clock);
      d = cmd_done;
      r = cmd_refused;
    end
    chk(d === ok && r === !ok, "command outcome");
    if (!ok)
      chk(n_arr == a, "array touched on refusal");
    // Deselect gap above the 10-cycle minimum
    repeat (12) @(negedge clock);
  endtask
  task automatic wen();
    run({56'h0, OPC_WR_EN}, 8, 1'b1);
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Erase kinds with their expected array op and alignment
  logic [7:0] eop [3] = '{OPC_ERASE_4K, OPC_ERASE_32K, OPC_ERASE_64K};
  fwg_arr_op_e eexp [3] = '{ARR_ERASE_4K, ARR_ERASE_32K, ARR_ERASE_64K};
  logic [20:0] emsk [3] = '{MASK_SUB4, MASK_SUB32, MASK_SECTOR};
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    quad_mode = 1'b0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (10) @(negedge clock);
    chk(status === 6'h00 && lock_write === 32'h0 && lock_down === 32'h0, "reset state");
    run({24'h0, OPC_PROG, 24'h012345, 8'ha5}, 40, 1'b0);
    wen();
    chk(status.wel === 1'b1, "latch not set");
    run({23'h0, OPC_PROG, 24'h012345, 8'ha5, 1'b0}, 41, 1'b0);
    chk(status.wel === 1'b1, "latch lost on refusal");
    run({24'h0, OPC_PROG, 24'h012345, 8'ha5}, 40, 1'b1);
    chk(last === {ARR_PROG, 21'h012345, 8'ha5} && status.wel === 1'b0, "program request");
    wen();
    run({24'h0, OPC_OTP_PROG, 24'h000047, 8'h3c}, 40, 1'b1);
    chk(last === {ARR_OTP_PROG, 21'h000007, 8'h3c}, "one-time request");
    for (int k = 0; k < 3; k++)
    begin
      wen();
      run({32'h0, eop[k], 24'h0abcde}, 32, 1'b1);
      chk(last.op === eexp[k] && last.addr === (21'h0abcde & emsk[k]), "erase request");
    end
    wen();
    run({48'h0, OPC_STATUS_WR, 8'h04}, 16, 1'b1);
    chk(status.bp === 3'h1 && status.tb === 1'b0, "range bits");
    wen();
    run({24'h0, OPC_PROG, 24'h1f0000, 8'h00}, 40, 1'b0);
    run({24'h0, OPC_PROG, 24'h1effff, 8'h00}, 40, 1'b1);
    wen();
    run({48'h0, OPC_STATUS_WR, 8'h24}, 16, 1'b1);
    wen();
    run({24'h0, OPC_PROG, 24'h00ff00, 8'h00}, 40, 1'b0);
    run({24'h0, OPC_PROG, 24'h010000, 8'h00}, 40, 1'b1);
    wen();
    @(posedge clock);
    wp_n <= 1'b0;
    run({48'h0, OPC_STATUS_WR, 8'h00}, 16, 1'b0);
    chk(status.bp === 3'h1 && status.tb === 1'b1, "range bits changed");
    @(posedge clock);
    quad_mode <= 1'b1;
    run({48'h0, OPC_STATUS_WR, 8'h00}, 16, 1'b1);
    chk(status.bp === 3'h0 && status.tb === 1'b0, "quad mode pin lock");
    @(posedge clock);
    wp_n <= 1'b1;
    quad_mode <= 1'b0;
    wen();
    run({48'h0, OPC_STATUS_WR, 8'h00}, 16, 1'b1);
    wen();
    run({56'h0, OPC_ERASE_ALL}, 8, 1'b1);
    chk(last.op === ARR_ERASE_ALL && last.addr === 21'h0, "bulk erase");
    wen();
    run({24'h0, OPC_LOCK_WR, 24'h030000, 8'h01}, 40, 1'b1);
    chk(lock_write === 32'h0000_0008, "write-lock bit");
    wen();
    run({24'h0, OPC_PROG, 24'h03f000, 8'h00}, 40, 1'b0);
    run({24'h0, OPC_LOCK_WR, 24'h030000, 8'h03}, 40, 1'b1);
    wen();
    run({24'h0, OPC_LOCK_WR, 24'h030000, 8'h00}, 40, 1'b0);
    chk(lock_write === 32'h0000_0008 && lock_down === 32'h0000_0008, "frozen lock");
    run({56'h0, OPC_ERASE_ALL}, 8, 1'b0);
    run({56'h0, OPC_WR_DIS}, 8, 1'b1);
    chk(status.wel === 1'b0, "latch not cleared");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(negedge clock);
    chk(lock_write === 32'h0 && lock_down === 32'h0, "lock after reset");
    give_verdict();
  end
endmodule
